// File: rtl/dshp_pkg.sv
// package for the converter serial host port: frame sizes, fifo depth
// assumes one 20 MHz system clock; all link pins sampled synchronously
package dshp_pkg;
	localparam int unsigned FRAME_BITS = 24;
	localparam int unsigned CNT_W = 5;
	localparam logic [4:0] FRAME_LAST = 5'h17;
	localparam int unsigned BYTE_BITS = 8;
	localparam int unsigned DATA_W = 24;
	localparam int unsigned FIFO_DEPTH = 4;
	localparam logic [23:0] DATA_RESET = 24'h000000;
	typedef enum logic [2:0] {
		DSHP_IDLE = 3'b001,
		DSHP_SHIFT = 3'b010,
		DSHP_DONE = 3'b100
	} dshp_state_t;
endpackage

// File: rtl/dshp_top.sv
// serial input port of the converter: shifts 24-bit frames, buffers them, updates output
// assumes sclk, frame sync, data and load pins already synchronous to clk_i
`timescale 1ns/1ns
`default_nettype none

module dshp_fifo #(
	parameter int unsigned WIDTH = 24,
	parameter int unsigned DEPTH = 4
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic [WIDTH-1:0] in_data_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	output logic [WIDTH-1:0] out_data_o,
	output logic out_valid_o,
	input wire logic out_ready_i
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
	logic [AW:0] cnt_reg, cnt_next;
	logic push, pop;
	always_comb begin
		push = in_valid_i && (cnt_reg != (AW+1)'(DEPTH));
		pop = out_ready_i && (cnt_reg != '0);
		wr_next = push ? wr_reg + 1'b1 : wr_reg;
		rd_next = pop ? rd_reg + 1'b1 : rd_reg;
		cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
	end
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
		end else begin
			wr_reg <= wr_next;
			rd_reg <= rd_next;
			cnt_reg <= cnt_next;
		end
		if (push)
			mem_reg[wr_reg] <= in_data_i;
	end
	assign in_ready_o = (cnt_reg != (AW+1)'(DEPTH));
	assign out_valid_o = (cnt_reg != '0);
	assign out_data_o = mem_reg[rd_reg];
endmodule // dshp_fifo

module dshp_top (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic sclk_i,
	input wire logic serial_data_input_i,
	input wire logic host_transmit_frame_n_i,
	input wire logic load_output_n_i,
	input wire logic readback_en_i,
	output logic serial_readback_out_o,
	output logic [15:0] dac_value_o,
	output logic [7:0] dac_ctrl_o,
	output logic update_o,
	output logic frame_ready_o
);
	dshp_pkg::dshp_state_t st_reg, st_next;
	logic [23:0] sh_reg, sh_next, dac_reg, dac_next, rb_reg, rb_next;
	logic [4:0] cnt_reg, cnt_next;
	logic sclk_d_reg, sync_d_reg, load_d_reg, so_reg, so_next, upd_reg, upd_next;
	logic frdy_reg, frdy_next;
	logic push, fifo_ready, f_valid, pop;
	logic [23:0] f_data;
	logic fall, rise, sync_rise, load_fall;

	always_comb begin
		fall = sclk_d_reg && !sclk_i;
		rise = !sclk_d_reg && sclk_i;
		sync_rise = !sync_d_reg && host_transmit_frame_n_i;
		load_fall = load_d_reg && !load_output_n_i;
		st_next = st_reg;
		sh_next = sh_reg;
		cnt_next = cnt_reg;
		push = 1'b0;
		case (st_reg)
			dshp_pkg::DSHP_IDLE: begin
				cnt_next = '0;
				if (!host_transmit_frame_n_i)
					st_next = dshp_pkg::DSHP_SHIFT;
			end
			dshp_pkg::DSHP_SHIFT: begin
				if (host_transmit_frame_n_i) begin
					// short frames are dropped
					st_next = dshp_pkg::DSHP_IDLE;
				end else if (fall) begin
					sh_next = {sh_reg[22:0], serial_data_input_i};
					cnt_next = cnt_reg + 1'b1;
					if (cnt_reg == dshp_pkg::FRAME_LAST)
						st_next = dshp_pkg::DSHP_DONE;
				end
			end
			dshp_pkg::DSHP_DONE: begin
				// extra clocks beyond 24 are ignored
				if (sync_rise) begin
					push = fifo_ready;
					st_next = dshp_pkg::DSHP_IDLE;
				end
			end
			default: st_next = dshp_pkg::DSHP_IDLE;
		endcase
	end

	dshp_fifo #(
		.WIDTH(dshp_pkg::DATA_W),
		.DEPTH(dshp_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.in_data_i(sh_reg),
		.in_valid_i(push),
		.in_ready_o(fifo_ready),
		.out_data_o(f_data),
		.out_valid_o(f_valid),
		.out_ready_i(pop)
	);

	always_comb begin
		// load low applies one frame per clk_i cycle, edge or not; held low it updates each frame
		pop = f_valid && (!load_output_n_i && (load_fall || !load_d_reg));
		dac_next = pop ? f_data : dac_reg;
		upd_next = pop;
		// pin from a flop, so it lags the fifo count by one cycle
		frdy_next = f_valid;
		rb_next = rb_reg;
		so_next = so_reg;
		if (!readback_en_i || host_transmit_frame_n_i) begin
			rb_next = dac_reg;
			so_next = dac_reg[23];
		end else if (rise) begin
			rb_next = {rb_reg[22:0], 1'b0};
			so_next = rb_reg[22];
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			st_reg <= dshp_pkg::DSHP_IDLE;
			sh_reg <= dshp_pkg::DATA_RESET;
			cnt_reg <= '0;
			dac_reg <= dshp_pkg::DATA_RESET;
			rb_reg <= dshp_pkg::DATA_RESET;
			so_reg <= 1'b0;
			upd_reg <= 1'b0;
			frdy_reg <= 1'b0;
			sclk_d_reg <= 1'b0;
			sync_d_reg <= 1'b1;
			load_d_reg <= 1'b1;
		end else begin
			st_reg <= st_next;
			sh_reg <= sh_next;
			cnt_reg <= cnt_next;
			dac_reg <= dac_next;
			rb_reg <= rb_next;
			so_reg <= so_next;
			upd_reg <= upd_next;
			frdy_reg <= frdy_next;
			sclk_d_reg <= sclk_i;
			sync_d_reg <= host_transmit_frame_n_i;
			load_d_reg <= load_output_n_i;
		end
	end

	always_comb begin
		serial_readback_out_o = so_reg;
		dac_value_o = dac_reg[15:0];
		dac_ctrl_o = dac_reg[23:16];
		update_o = upd_reg;
		frame_ready_o = frdy_reg;
	end

	sequence s_full_frame;
		(st_reg == dshp_pkg::DSHP_DONE) ##1 sync_rise;
	endsequence
	chk_frame_push: assert property (@(posedge clk_i) disable iff (srst_i)
		s_full_frame ##0 fifo_ready |-> push)
		else $error("complete frame not queued");
	chk_drop_full: assert property (@(posedge clk_i) disable iff (srst_i)
		s_full_frame ##0 !fifo_ready |-> !push)
		else $error("frame queued into full fifo");
	chk_done_count: assert property (@(posedge clk_i) disable iff (srst_i)
		(st_reg == dshp_pkg::DSHP_DONE) |-> cnt_reg == dshp_pkg::FRAME_LAST + 5'h01)
		else $error("frame done without 24 bits");
	chk_short_drop: assert property (@(posedge clk_i) disable iff (srst_i)
		(st_reg == dshp_pkg::DSHP_SHIFT) && host_transmit_frame_n_i
		|=> !push && (st_reg == dshp_pkg::DSHP_IDLE))
		else $error("short frame accepted");
	chk_load_update: assert property (@(posedge clk_i) disable iff (srst_i)
		f_valid && load_fall |=> upd_reg && dac_reg == $past(f_data))
		else $error("load did not update output");
	chk_auto_update: assert property (@(posedge clk_i) disable iff (srst_i)
		push && !load_output_n_i && !load_d_reg && !f_valid |=> ##1 upd_reg)
		else $error("auto update missing");
	chk_hold_no_load: assert property (@(posedge clk_i) disable iff (srst_i)
		load_output_n_i |=> $stable(dac_reg))
		else $error("output changed without load");
	chk_shift_msb: assert property (@(posedge clk_i) disable iff (srst_i)
		(st_reg == dshp_pkg::DSHP_SHIFT) && !host_transmit_frame_n_i && fall
		|=> sh_reg[0] == $past(serial_data_input_i))
		else $error("bit not shifted at falling edge");
	chk_readback_load: assert property (@(posedge clk_i) disable iff (srst_i)
		!readback_en_i |=> serial_readback_out_o == $past(dac_reg[23]))
		else $error("readback msb wrong");
	chk_no_shift_idle: assert property (@(posedge clk_i) disable iff (srst_i)
		host_transmit_frame_n_i |=> $stable(cnt_reg) || cnt_reg == '0)
		else $error("shift outside frame");
endmodule // dshp_top
`default_nettype wire

// File: tb/dshp_host.sv
// host serial master model: msb first, clock idles low, data on rise
// assumes the bench calls send() just after a clk_i rising edge
`timescale 1ns/1ns
`default_nettype none
module dshp_host (
	input wire logic clk_i,
	output logic sclk_o,
	output logic data_o,
	output logic sync_n_o
);
	initial begin
		sclk_o = 1'b0;
		data_o = 1'b0;
		sync_n_o = 1'b1;
	end
	task automatic send(input logic [23:0] w, input int n);
		sync_n_o <= 1'b0;
		repeat (2) @(posedge clk_i);
		for (int i = 23; i > 23 - n; i--) begin
			sclk_o <= 1'b1;
			data_o <= w[i];
			repeat (2) @(posedge clk_i);
			sclk_o <= 1'b0;
			repeat (2) @(posedge clk_i);
		end
		sync_n_o <= 1'b1;
		data_o <= ~data_o; // released line must not keep last bit
		repeat (2) @(posedge clk_i);
	endtask
endmodule // dshp_host
`default_nettype wire

// File: tb/tb_top.sv
// bench: random frames against a queue model of the buffered output word
// assumes 20 MHz clk_i and the host model driving the link pins
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic load_n = 1'b1;
	logic rb_en = 1'b0;
	logic sclk, sdi, sync_n, rb, upd, frdy;
	logic [15:0] val;
	logic [7:0] ctl;
	logic [23:0] q[$];
	logic [23:0] w, exp_w;
	int miscompares = 0;
	int tests_run = 0;
	int seed = 92;
	always #25 clk_i = ~clk_i;
	dshp_host host (.clk_i(clk_i), .sclk_o(sclk), .data_o(sdi), .sync_n_o(sync_n));
	dshp_top DUT (.clk_i(clk_i), .srst_i(srst_i), .sclk_i(sclk), .serial_data_input_i(sdi),
		.host_transmit_frame_n_i(sync_n), .load_output_n_i(load_n), .readback_en_i(rb_en),
		.serial_readback_out_o(rb), .dac_value_o(val), .dac_ctrl_o(ctl), .update_o(upd),
		.frame_ready_o(frdy));
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// bound covers a whole frame when run beside send()
	task automatic expect_update();
		for (int k = 0; k < 200; k++) begin
			#1;
			if (upd === 1'b1) begin
				exp_w = q.pop_front();
				check({ctl, val}, exp_w);
				return;
			end
			@(posedge clk_i);
		end
		miscompares++;
		end_of_test();
	endtask
	initial begin
		repeat (5) @(posedge clk_i);
		srst_i <= 1'b0;
		@(posedge clk_i);
		for (int i = 0; i < 5; i++) begin
			w = 24'($random(seed));
			host.send(w, 24);
			if (i < 4)
				q.push_back(w); // fifo of 4 drops the fifth
		end
		#1;
		check({ctl, val}, 24'h000000);
		check(24'(frdy), 24'h000001);
		for (int i = 0; i < 4; i++) begin
			// one cycle of load low, so exactly one queued frame is applied
			@(posedge clk_i);
			load_n <= 1'b0;
			@(posedge clk_i);
			load_n <= 1'b1;
			expect_update();
		end
		repeat (3) @(posedge clk_i);
		#1;
		check(24'({frdy, rb}), 24'({1'b0, exp_w[23]}));
		@(posedge clk_i);
		load_n <= 1'b0;
		rb_en <= 1'b1;
		w = 24'($random(seed));
		host.send(w, 23);
		repeat (4) @(posedge clk_i);
		#1;
		check({ctl, val}, exp_w);
		for (int i = 0; i < 3; i++) begin
			@(posedge clk_i);
			w = 24'($random(seed));
			q.push_back(w);
			fork
				host.send(w, 24);
				expect_update();
			join
		end
		repeat (4) @(posedge clk_i);
		#1;
		check(24'(rb), 24'(exp_w[23]));
		end_of_test();
	end
endmodule // tb_top
`default_nettype wire
